//--- rtl/lwdt_map.svh
`ifndef LWDT_MAP_SVH
`define LWDT_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LWDT_CLK_PERIOD_NS 10
`define LWDT_LF_PERIOD_NS  12500
// least period rounds up to whole core cycles
`define LWDT_LF_DIV ((`LWDT_LF_PERIOD_NS + `LWDT_CLK_PERIOD_NS - 1) / `LWDT_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// interval selection
// ----------------------------------------------------------------
`define LWDT_SEL_W       3
`define LWDT_SEL_RESET   3'h7
`define LWDT_BASE_EXP    6

`endif

//--- rtl/lwdt_pkg.sv
`default_nettype none

package lwdt_pkg;

	typedef enum logic [2:0] {
		LWDT_RUN   = 3'b001,
		LWDT_OFF   = 3'b010,
		LWDT_FIRED = 3'b100
	} lwdt_state_t;

endpackage
`default_nettype wire

//--- rtl/lwdt_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "lwdt_map.svh"

module lwdt_tick_gen #(
	parameter int unsigned DIV = `LWDT_LF_DIV
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// low-frequency enable
	output logic      lf_tick
);

	if (DIV < 2)
	begin : g_bad_div
		$error("lwdt_tick_gen: DIV must be at least 2");
	end

	localparam int unsigned DW = $clog2(DIV);

	logic [DW-1:0] div_cnt;
	wire           div_wrap = (div_cnt == DW'(DIV - 1));

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			div_cnt <= '0;
		else if (div_wrap)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + DW'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			lf_tick <= 1'b0;
		else
			lf_tick <= div_wrap;
	end

endmodule
`default_nettype wire

//--- rtl/lwdt_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lwdt_map.svh"

// What this block does
// - counter advances only on low-frequency ticks
// - enabled overflow raises a system reset request
// - after reset enabled, longest interval selected
// - software may disable unless locked
// - lock blocks disable and setting changes
// - overflow reset leaves external reset pin alone
// - software selects timeout length in ticks
// - any reset restores every register's default
module lwdt_top #(
	parameter int unsigned LF_DIV   = `LWDT_LF_DIV,
	parameter int unsigned BASE_EXP = `LWDT_BASE_EXP
) (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	// software commands, one-cycle pulses
	input  wire logic                    restart_req,
	input  wire logic                    disable_req,
	input  wire logic                    enable_req,
	input  wire logic                    lock_req,
	input  wire logic                    interval_wr,
	input  wire logic [`LWDT_SEL_W-1:0]  interval_sel,
	// status
	output logic                         wdt_enabled,
	output logic                         wdt_locked,
	output logic [`LWDT_SEL_W-1:0]       wdt_interval,
	output logic [BASE_EXP+6:0]          watchdog_counter,
	// to system reset logic
	output logic                         wdt_reset_req
);

	if (BASE_EXP < 1 || BASE_EXP > 20)
	begin : g_bad_exp
		$error("lwdt_top: BASE_EXP out of range");
	end

	localparam int unsigned CW = BASE_EXP + 7;

	// ----------------------------------------------------------------
	// low-frequency time base
	// ----------------------------------------------------------------
	logic lf_tick;

	// counter logic only moves on this enable
	lwdt_tick_gen #(
		.DIV      (LF_DIV)
	) u_tick (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.lf_tick  (lf_tick)
	);

	// ----------------------------------------------------------------
	// command capture
	// ----------------------------------------------------------------
	// requests wait here until the next tick; a request landing on the
	// consuming tick stays pending so it is never lost
	localparam int unsigned NCMD = 5;

	wire  [NCMD-1:0]        cmd_req;
	logic [NCMD-1:0]        cmd_pend;
	logic [`LWDT_SEL_W-1:0] sel_val;

	assign cmd_req = {interval_wr, lock_req, enable_req, disable_req, restart_req};

	for (genvar i = 0; i < NCMD; i++)
	begin : g_pend
		always_ff @(posedge core_clk)
		begin
			if (sys_rst)
				cmd_pend[i] <= 1'b0;
			else
				cmd_pend[i] <= (cmd_pend[i] & ~lf_tick) | cmd_req[i];
		end
	end

	wire                    rst_pend = cmd_pend[0];
	wire                    dis_pend = cmd_pend[1];
	wire                    ena_pend = cmd_pend[2];
	wire                    lck_pend = cmd_pend[3];
	wire                    sel_pend = cmd_pend[4];

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			sel_val <= `LWDT_SEL_RESET;
		else if (interval_wr)
			sel_val <= interval_sel;
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	lwdt_pkg::lwdt_state_t state;
	lwdt_pkg::lwdt_state_t next_state;

	wire          is_run     = (state == lwdt_pkg::LWDT_RUN);
	wire          is_off     = (state == lwdt_pkg::LWDT_OFF);
	// lock pending in the same tick already shields the settings
	wire          may_change = ~wdt_locked & ~lck_pend;
	wire          do_disable = lf_tick & dis_pend & may_change;
	wire          do_enable  = lf_tick & (ena_pend | lck_pend);
	wire          do_restart = lf_tick & rst_pend;
	wire          do_sel     = lf_tick & sel_pend & may_change;
	wire [CW-1:0] terminal   = {CW{1'b1}} >> (`LWDT_SEL_RESET - wdt_interval);
	// at or above, so a shortened interval below the count fires on the next tick
	wire          at_end     = (watchdog_counter >= terminal);
	wire          overflow   = is_run & lf_tick & ~do_restart & ~do_disable & at_end;

	always_comb
	begin
		next_state = state;
		case (state)
			lwdt_pkg::LWDT_RUN:
				if (overflow)
					next_state = lwdt_pkg::LWDT_FIRED;
				else if (do_disable)
					next_state = lwdt_pkg::LWDT_OFF;
			lwdt_pkg::LWDT_OFF:
				if (do_enable)
					next_state = lwdt_pkg::LWDT_RUN;
			lwdt_pkg::LWDT_FIRED:
				next_state = lwdt_pkg::LWDT_FIRED;
			default:
				next_state = lwdt_pkg::LWDT_RUN;
		endcase
	end

	// ----------------------------------------------------------------
	// state and settings
	// ----------------------------------------------------------------
	// every reset, the watchdog's own included, lands here
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			state <= lwdt_pkg::LWDT_RUN;
		else
			state <= next_state;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			wdt_interval <= `LWDT_SEL_RESET;
		else if (do_sel)
			wdt_interval <= sel_val;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			wdt_locked <= 1'b0;
		else if (lf_tick & lck_pend)
			wdt_locked <= 1'b1;
	end

	// ----------------------------------------------------------------
	// watchdog counter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			watchdog_counter <= '0;
		else if (do_restart | (is_off & do_enable))
			watchdog_counter <= '0;
		else if (is_run & lf_tick & ~at_end)
			watchdog_counter <= watchdog_counter + CW'(1);
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// request stays up until the system reset logic answers with sys_rst;
	// there is deliberately no path to the external reset pin
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			wdt_reset_req <= 1'b0;
		else if (overflow)
			wdt_reset_req <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			wdt_enabled <= 1'b1;
		else
			wdt_enabled <= (next_state != lwdt_pkg::LWDT_OFF);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_reset_defaults;
		@(posedge core_clk) disable iff (1'b0)
		sys_rst |=> (state == lwdt_pkg::LWDT_RUN) && (wdt_interval == `LWDT_SEL_RESET)
			&& !wdt_locked && wdt_enabled && (watchdog_counter == '0);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state");

	property p_count_on_tick;
		!lf_tick |=> $stable(watchdog_counter);
	endproperty
	a_count_on_tick: assert property (p_count_on_tick) else $error("count moved off tick");

	property p_fire;
		is_run && lf_tick && !rst_pend && !dis_pend && at_end |=> wdt_reset_req;
	endproperty
	a_fire: assert property (p_fire) else $error("overflow missed");

	property p_req_holds;
		wdt_reset_req |=> wdt_reset_req [*2];
	endproperty
	a_req_holds: assert property (p_req_holds) else $error("reset request dropped");

	property p_disable;
		is_run && lf_tick && dis_pend && !wdt_locked && !lck_pend && !at_end
			|=> !wdt_enabled && is_off;
	endproperty
	a_disable: assert property (p_disable) else $error("disable not taken");

	property p_locked_on;
		wdt_locked |=> !is_off && wdt_locked;
	endproperty
	a_locked_on: assert property (p_locked_on) else $error("locked watchdog went off");

	property p_locked_sel;
		wdt_locked |=> $stable(wdt_interval);
	endproperty
	a_locked_sel: assert property (p_locked_sel) else $error("locked interval changed");

	property p_restart;
		lf_tick && rst_pend && !is_off && !lck_pend
			|=> watchdog_counter == '0 && $stable(wdt_locked);
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not clear");

	property p_sync;
		restart_req && !wdt_reset_req ##1 !lf_tick [*2] |-> rst_pend;
	endproperty
	a_sync: assert property (p_sync) else $error("restart not held pending");

	property p_sel_apply;
		lf_tick && sel_pend && !wdt_locked && !lck_pend |=> wdt_interval == $past(sel_val);
	endproperty
	a_sel_apply: assert property (p_sel_apply) else $error("interval not applied");

	// cycles since the last tick, for any divider value
	localparam int unsigned GW = $clog2(LF_DIV + 1);

	logic [GW-1:0] gap_cnt;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			gap_cnt <= '0;
		else if (lf_tick)
			gap_cnt <= GW'(1);
		else
			gap_cnt <= gap_cnt + GW'(1);
	end

	property p_tick_gap;
		lf_tick == (gap_cnt == GW'(LF_DIV));
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");

endmodule
`default_nettype wire

//--- tb/lwdt_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lwdt_map.svh"

module lwdt_top_tb_top;
	// short divider and exponent keep every timeout brief
	localparam int unsigned LF_DIV   = 10;
	localparam int unsigned BASE_EXP = 1;

	logic                   core_clk = 1'b0;
	logic                   sys_rst = 1'b1;
	logic                   restart_req = 1'b0;
	logic                   disable_req = 1'b0;
	logic                   enable_req = 1'b0;
	logic                   lock_req = 1'b0;
	logic                   interval_wr = 1'b0;
	logic [`LWDT_SEL_W-1:0] interval_sel = 3'h0;
	logic                   wdt_enabled;
	logic                   wdt_locked;
	logic [`LWDT_SEL_W-1:0] wdt_interval;
	logic [BASE_EXP+6:0]    watchdog_counter;
	logic                   wdt_reset_req;
	int                     err_count = 0;
	int                     n_tests = 0;

	lwdt_top #(.LF_DIV(LF_DIV), .BASE_EXP(BASE_EXP)) uut (
		.core_clk(core_clk), .sys_rst(sys_rst), .restart_req(restart_req),
		.disable_req(disable_req), .enable_req(enable_req), .lock_req(lock_req),
		.interval_wr(interval_wr), .interval_sel(interval_sel),
		.wdt_enabled(wdt_enabled), .wdt_locked(wdt_locked),
		.wdt_interval(wdt_interval), .watchdog_counter(watchdog_counter),
		.wdt_reset_req(wdt_reset_req)
	);

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
	endtask

	// one-cycle command pulse; k picks the command, 4 writes interval and restarts together
	task automatic pulse(input int k, input logic [2:0] sel);
		@(negedge core_clk);
		restart_req = (k == 0 || k == 4);
		disable_req = (k == 1);
		enable_req = (k == 2);
		lock_req = (k == 3);
		interval_wr = (k == 4 || k == 5);
		interval_sel = sel;
		@(negedge core_clk);
		{restart_req, disable_req, enable_req, lock_req, interval_wr} = 5'h00;
	endtask

	task automatic settle();
		repeat (LF_DIV + 2) @(negedge core_clk);
	endtask

	task automatic check_defaults();
		check("enabled", wdt_enabled, 1);
		check("locked", wdt_locked, 0);
		check("interval", wdt_interval, 7);
		check("reset_req", wdt_reset_req, 0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_tick_rate();
		logic [BASE_EXP+6:0] c0;
		do_reset();
		check_defaults();
		check("counter", watchdog_counter, 0);
		repeat (2 * LF_DIV) @(negedge core_clk);
		c0 = watchdog_counter;
		check("first tick", c0, 1);
		repeat (LF_DIV) @(negedge core_clk);
		check("counter step", watchdog_counter, c0 + 1);
	endtask

	task automatic test_interval(input int c);
		int n;
		int exp;
		do_reset();
		repeat (2 * LF_DIV) @(negedge core_clk);
		pulse(4, c[2:0]);
		n = 0;
		while (watchdog_counter !== 0 && n < LF_DIV + 2)
		begin
			@(negedge core_clk);
			n++;
		end
		check("restart zero", watchdog_counter, 0);
		check("interval", wdt_interval, c);
		// every code, the longest too, fires exactly 2^(BASE_EXP+c) ticks after the clear
		exp = (1 << (BASE_EXP + c)) * LF_DIV;
		n = 0;
		while (wdt_reset_req !== 1'b1 && n < exp + 20)
		begin
			@(negedge core_clk);
			n++;
		end
		check("timeout", n, exp);
		repeat (3 * LF_DIV) @(negedge core_clk);
		check("reset_req held", wdt_reset_req, 1);
		do_reset();
		check_defaults();
	endtask

	task automatic test_disable();
		logic [BASE_EXP+6:0] c0;
		do_reset();
		pulse(1, 3'h0);
		settle();
		check("enabled", wdt_enabled, 0);
		c0 = watchdog_counter;
		repeat (3 * LF_DIV) @(negedge core_clk);
		check("frozen", watchdog_counter, c0);
		check("reset_req", wdt_reset_req, 0);
		pulse(2, 3'h0);
		settle();
		check("enabled", wdt_enabled, 1);
		check("counter cleared", watchdog_counter, 0);
	endtask

	task automatic test_lock();
		do_reset();
		// locking from the off state turns the watchdog back on
		pulse(1, 3'h0);
		settle();
		check("enabled", wdt_enabled, 0);
		pulse(3, 3'h0);
		settle();
		check("locked", wdt_locked, 1);
		check("enabled", wdt_enabled, 1);
		pulse(1, 3'h0);
		pulse(5, 3'h0);
		settle();
		check("enabled", wdt_enabled, 1);
		check("interval", wdt_interval, 7);
		do_reset();
		check_defaults();
	endtask

	// one restart per tick keeps a two-tick timeout from firing
	task automatic test_restart_keeps();
		do_reset();
		pulse(5, 3'h0);
		repeat (8)
		begin
			pulse(0, 3'h0);
			repeat (LF_DIV - 2) @(negedge core_clk);
		end
		check("interval", wdt_interval, 0);
		check("reset_req kept", wdt_reset_req, 0);
		repeat (4 * LF_DIV) @(negedge core_clk);
		check("reset_req late", wdt_reset_req, 1);
		do_reset();
		check_defaults();
	endtask

	initial
	begin
		repeat (30000) @(posedge core_clk);
		err_count++;
		print_verdict();
	end

	initial
	begin
		test_tick_rate();
		for (int c = 0; c < 8; c++)
			test_interval(c);
		test_disable();
		test_restart_keeps();
		test_lock();
		print_verdict();
	end
endmodule

`default_nettype wire
